// *** hdl/scsi_rate_pkg.sv ***
// Purpose: shared constants and types for the synchronous rate divider
// Assumes: i_clk is the scsi clock itself
// Notes: register offsets are byte addresses on the avalon slave
package scsi_rate_pkg;
	localparam int DIV_W = 4;
	typedef logic [DIV_W-1:0] div_t;

	localparam logic [3:0] OFF_TIMING = 4'h0;
	localparam logic [3:0] OFF_XFER = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h8;

	localparam logic [7:0] TIMING_RESET = 8'h00;
	localparam logic [7:0] XFER_RESET = 8'h00;

	localparam logic [2:0] CODE_DIV1 = 3'h1;
	localparam logic [2:0] CODE_DIV2 = 3'h3;
	localparam logic [2:0] CODE_DIV4 = 3'h5;

	localparam div_t DIV_ONE = 4'h1;
	localparam div_t DIV_TWO = 4'h2;
	localparam div_t DIV_FOUR = 4'h4;
	localparam div_t TP_BASE_DIV = 4'h4;
	localparam div_t RECV_DIV = 4'h4;

	typedef struct packed {
		logic ultra_en;
		logic [2:0] sync_clock_divider_field;
		logic rsvd;
		logic [2:0] core_clock_divider_field;
	} timing_ctrl_t;

	typedef struct packed {
		logic [2:0] send_period_field;
		logic [4:0] sync_offset;
	} sync_xfer_t;

	typedef struct packed {
		logic ultra_active;
		logic [2:0] sync_div;
		logic rsvd;
		logic [2:0] core_div;
	} rate_status_t;

	typedef struct packed {
		logic we;
		logic [3:0] addr;
		logic [7:0] data;
	} script_wr_t;

	// unlisted codes fall back to divide-by-1
	function automatic div_t clk_div_decode(input logic [2:0] code);
		div_t d;
		d = DIV_ONE;
		case (code)
			CODE_DIV1: d = DIV_ONE;
			CODE_DIV2: d = DIV_TWO;
			CODE_DIV4: d = DIV_FOUR;
			default: d = DIV_ONE;
		endcase
		return d;
	endfunction

	function automatic div_t send_div_decode(input logic [2:0] code);
		return TP_BASE_DIV + {1'b0, code};
	endfunction
endpackage

// *** hdl/sync_scsi_rate_divider.sv ***
// Purpose: synchronous and core rate dividers with their setup registers
// Assumes: i_clk is the scsi clock; avalon-mm slave with waitrequest
// Notes: every rate is a one-cycle enable pulse, no derived clocks
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`default_nettype none

module tick_divider (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_src,
	input wire logic i_restart,
	input wire scsi_rate_pkg::div_t i_div,
	output logic o_tick
);
	import scsi_rate_pkg::*;
	div_t cnt_q;
	div_t cnt_d;
	div_t div_last;
	logic wrap;

	assign div_last = i_div - DIV_ONE;
	assign wrap = i_src && (cnt_q == div_last);
	assign cnt_d = (i_restart || wrap) ? '0 :
		(i_src ? cnt_q + DIV_ONE : cnt_q);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= '0;
			o_tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			o_tick <= wrap && !i_restart;
		end
	end
endmodule // tick_divider

module sync_scsi_rate_divider
	import scsi_rate_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	input wire script_wr_t i_script_wr,
	input wire logic i_sync_phase,
	output timing_ctrl_t o_timing_ctrl,
	output sync_xfer_t o_sync_xfer,
	output logic [4:0] o_sync_offset,
	output logic o_ultra_en,
	output logic o_sync_tick,
	output logic o_core_tick,
	output logic o_recv_tick,
	output logic o_send_tick,
	output logic o_send_strobe
);
	timing_ctrl_t timing_q;
	sync_xfer_t xfer_q;
	rate_status_t status;
	logic req;
	logic host_wr;
	logic timing_wr;
	logic xfer_wr;
	logic sync_restart;
	logic send_restart;
	logic [7:0] wr_byte;
	logic [7:0] rd_byte;
	div_t sync_div_raw;
	div_t sync_div;
	div_t core_div;
	div_t send_div;

	// bus side: one wait state per access, commit when waitrequest is low
	assign req = i_read || i_write;
	assign host_wr = i_write && !o_waitrequest && i_byteenable[0];
	// script writes win a same-cycle collision, the host write is dropped
	assign timing_wr = i_script_wr.we ? (i_script_wr.addr == OFF_TIMING) :
		(host_wr && i_address == OFF_TIMING);
	assign xfer_wr = i_script_wr.we ? (i_script_wr.addr == OFF_XFER) :
		(host_wr && i_address == OFF_XFER);
	assign wr_byte = i_script_wr.we ? i_script_wr.data : i_writedata[7:0];

	assign rd_byte = (i_address == OFF_TIMING) ? timing_q :
		(i_address == OFF_XFER) ? xfer_q :
		(i_address == OFF_STATUS) ? status : 8'h00;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_waitrequest <= 1'b1;
			o_readdata <= 32'h0000_0000;
		end else begin
			o_waitrequest <= !(req && o_waitrequest);
			if (i_read && o_waitrequest) begin
				o_readdata <= {24'h00_0000, rd_byte};
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			timing_q <= TIMING_RESET;
			xfer_q <= XFER_RESET;
		end else begin
			if (timing_wr) begin
				timing_q <= {wr_byte[7:4], 1'b0, wr_byte[2:0]};
			end
			if (xfer_wr) begin
				xfer_q <= wr_byte;
			end
		end
	end

	// divisor selection
	assign sync_div_raw =
		clk_div_decode(timing_q.sync_clock_divider_field);
	// without ultra permission the undivided path is held back to half rate
	assign sync_div = (!timing_q.ultra_en && sync_div_raw == DIV_ONE) ?
		DIV_TWO : sync_div_raw;
	assign core_div =
		clk_div_decode(timing_q.core_clock_divider_field);
	assign send_div =
		send_div_decode(xfer_q.send_period_field);

	assign status.ultra_active = timing_q.ultra_en;
	assign status.sync_div = sync_div[2:0];
	assign status.rsvd = 1'b0;
	assign status.core_div = core_div[2:0];

	// any rewrite of a divider register restarts the affected chain
	assign sync_restart = timing_wr;
	assign send_restart = timing_wr || xfer_wr;

	tick_divider u_sync_div (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_src(1'b1),
		.i_restart(sync_restart),
		.i_div(sync_div),
		.o_tick(o_sync_tick)
	);

	tick_divider u_core_div (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_src(1'b1),
		.i_restart(sync_restart),
		.i_div(core_div),
		.o_tick(o_core_tick)
	);

	// receive pacing hangs off the sync divider only
	tick_divider u_recv_div (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_src(o_sync_tick),
		.i_restart(sync_restart),
		.i_div(RECV_DIV),
		.o_tick(o_recv_tick)
	);

	tick_divider u_send_div (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_src(o_sync_tick),
		.i_restart(send_restart),
		.i_div(send_div),
		.o_tick(o_send_tick)
	);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_send_strobe <= 1'b0;
			o_sync_offset <= 5'h00;
			o_ultra_en <= 1'b0;
		end else begin
			// role does not matter, only an active sync data phase
			o_send_strobe <= o_send_tick && i_sync_phase;
			o_sync_offset <= xfer_q.sync_offset;
			o_ultra_en <= timing_q.ultra_en;
		end
	end

	assign o_timing_ctrl = timing_q;
	assign o_sync_xfer = xfer_q;

	property p_wait_ack;
		@(posedge i_clk) disable iff (i_rst)
		req && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest;
	endproperty
	a_wait_ack: assert property (p_wait_ack)
		else $error("waitrequest did not give a single ack cycle");

	property p_host_timing_wr;
		@(posedge i_clk) disable iff (i_rst)
		(host_wr && i_address == OFF_TIMING && !i_script_wr.we) |=>
			(o_timing_ctrl == {$past(i_writedata[7:4]), 1'b0,
			$past(i_writedata[2:0])});
	endproperty
	a_host_timing_wr: assert property (p_host_timing_wr)
		else $error("host write to timing control not stored");

	property p_script_xfer_wr;
		@(posedge i_clk) disable iff (i_rst)
		(i_script_wr.we && i_script_wr.addr == OFF_XFER) |=>
			(o_sync_xfer == $past(i_script_wr.data)) ##1
			(o_sync_offset == $past(o_sync_xfer.sync_offset));
	endproperty
	a_script_xfer_wr: assert property (p_script_xfer_wr)
		else $error("script write to transfer setup not stored");

	property p_sync_div2;
		@(posedge i_clk) disable iff (i_rst)
		(o_sync_tick && sync_div == DIV_TWO && !sync_restart) ##1
			!sync_restart |=> o_sync_tick;
	endproperty
	a_sync_div2: assert property (p_sync_div2)
		else $error("sync divide-by-2 cadence wrong");

	property p_ultra_gate;
		@(posedge i_clk) disable iff (i_rst)
		(o_sync_tick && !timing_q.ultra_en) |=> !o_sync_tick;
	endproperty
	a_ultra_gate: assert property (p_ultra_gate)
		else $error("full-rate sync tick without ultra enable");

	// with ultra permitted the undivided path must really tick every cycle
	property p_ultra_full;
		@(posedge i_clk) disable iff (i_rst)
		(o_sync_tick && sync_div == DIV_ONE && !sync_restart) |=>
			o_sync_tick;
	endproperty
	a_ultra_full: assert property (p_ultra_full)
		else $error("ultra divide-by-1 did not tick every cycle");

	property p_core_div4;
		@(posedge i_clk) disable iff (i_rst)
		(o_core_tick && core_div == DIV_FOUR && !sync_restart) ##1
			(!sync_restart)[*3] |=> o_core_tick && !$past(o_core_tick);
	endproperty
	a_core_div4: assert property (p_core_div4)
		else $error("core divide-by-4 cadence wrong");

	property p_recv_quarter;
		@(posedge i_clk) disable iff (i_rst)
		o_recv_tick |=> (!o_recv_tick)[*3];
	endproperty
	a_recv_quarter: assert property (p_recv_quarter)
		else $error("receive tick faster than a quarter of sync rate");

	property p_send_min;
		@(posedge i_clk) disable iff (i_rst)
		o_send_tick |=> (!o_send_tick)[*3];
	endproperty
	a_send_min: assert property (p_send_min)
		else $error("send tick faster than divide-by-4");

	property p_strobe_cause;
		@(posedge i_clk) disable iff (i_rst)
		o_send_strobe |-> $past(o_send_tick) && $past(i_sync_phase);
	endproperty
	a_strobe_cause: assert property (p_strobe_cause)
		else $error("send strobe outside a sync data phase");

	property p_restart;
		@(posedge i_clk) disable iff (i_rst)
		timing_wr |=> !o_sync_tick && !o_recv_tick && !o_send_tick;
	endproperty
	a_restart: assert property (p_restart)
		else $error("divider did not restart on rewrite");

	property p_xfer_restart;
		@(posedge i_clk) disable iff (i_rst)
		xfer_wr |=> !o_send_tick;
	endproperty
	a_xfer_restart: assert property (p_xfer_restart)
		else $error("send divider did not restart on setup write");

	c_read: cover property (@(posedge i_clk) disable iff (i_rst)
		i_read && !o_waitrequest && i_address == OFF_STATUS);
	c_script_wr: cover property (@(posedge i_clk) disable iff (i_rst)
		i_script_wr.we && i_script_wr.addr == OFF_TIMING);
	c_ultra_send: cover property (@(posedge i_clk) disable iff (i_rst)
		o_send_strobe && timing_q.ultra_en && sync_div == DIV_ONE);
	c_fast_div4: cover property (@(posedge i_clk) disable iff (i_rst)
		o_recv_tick && sync_div == DIV_FOUR);
endmodule // sync_scsi_rate_divider

`default_nettype wire

// *** tb/scsi_peer.sv ***
// Purpose: far side peer that opens and closes synchronous data phases
// Assumes: phases are timed off the block's scsi clock
// Notes: phase lengths are random so strobes meet both phase edges
`default_nettype none
module scsi_peer (
	input wire logic i_clk,
	input wire logic i_run,
	output logic o_sync_phase
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	initial o_sync_phase = 1'b0;
	// a data phase looks the same in initiator and target role
	always @(posedge i_clk) begin
		if (n == 0) begin
			o_sync_phase <= i_run && !o_sync_phase;
			n = 3 + $urandom_range(0, 20);
		end else begin
			n = n - 1;
		end
	end
endmodule // scsi_peer
`default_nettype wire

// *** tb/tb_sync_scsi_rate_divider.sv ***
// Purpose: self-checking bench for the sync rate divider
// Assumes: one wait state per avalon access, ticks are one-cycle pulses
// Notes: periods are measured pulse to pulse, so restart phase is ignored
`default_nettype none
module tb_sync_scsi_rate_divider;
	import scsi_rate_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [3:0] i_address = 4'h0;
	logic [3:0] i_byteenable = 4'hf;
	logic [31:0] i_writedata = 32'h0;
	script_wr_t i_script_wr = '0;
	logic i_sync_phase;
	logic [31:0] o_readdata;
	logic o_waitrequest, o_ultra_en, o_sync_tick, o_core_tick;
	logic o_recv_tick, o_send_tick, o_send_strobe, ps;
	timing_ctrl_t o_timing_ctrl;
	sync_xfer_t o_sync_xfer;
	logic [4:0] o_sync_offset;
	logic [3:0] tk;
	int error_cnt = 0;
	int checks = 0;
	assign tk = {o_send_tick, o_recv_tick, o_core_tick, o_sync_tick};
	always #5 i_clk = ~i_clk;
	sync_scsi_rate_divider u_sync_scsi_rate_divider (.i_clk, .i_rst,
		.i_address, .i_read, .i_write, .i_writedata, .i_byteenable,
		.o_readdata, .o_waitrequest, .i_script_wr, .i_sync_phase,
		.o_timing_ctrl, .o_sync_xfer, .o_sync_offset, .o_ultra_en,
		.o_sync_tick, .o_core_tick, .o_recv_tick, .o_send_tick,
		.o_send_strobe);
	scsi_peer u_scsi_peer (.i_clk, .i_run(1'b1), .o_sync_phase(i_sync_phase));

	task automatic report_and_stop;
		if (error_cnt == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [7:0] d, output logic [31:0] q);
		int k;
		@(posedge i_clk);
		i_address <= a;
		i_write <= wr;
		i_read <= !wr;
		i_writedata <= {24'h0, d};
		// at each edge the values that stood before it are seen
		for (k = 0; k < 50; k++) begin
			@(posedge i_clk);
			if (o_waitrequest === 1'b0) break;
		end
		if (k == 50) begin
			error_cnt++;
			$display("mismatch at %0t: bus timeout", $time);
			report_and_stop();
		end
		q = o_readdata;
		i_write <= 1'b0;
		i_read <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h0, q);
		chk(q, {24'h0, e});
	endtask

	task automatic period(input int s, input int e);
		int n;
		for (n = 0; n < 400 && tk[s] !== 1'b1; n++) @(negedge i_clk);
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while (tk[s] !== 1'b1 && n < 400);
		if (n == 400) begin
			error_cnt++;
			$display("mismatch at %0t: tick timeout", $time);
			report_and_stop();
		end
		chk(n, e);
	endtask

	// without ultra enable a divide-by-1 runs at /2
	function automatic int sdiv(input logic [7:0] t);
		int d;
		d = (t[6:4] == 3'h3) ? 2 : (t[6:4] == 3'h5) ? 4 : 1;
		return (d == 1 && !t[7]) ? 2 : d;
	endfunction

	function automatic int cdiv(input logic [2:0] c);
		return (c == 3'h3) ? 2 : (c == 3'h5) ? 4 : 1;
	endfunction

	// strobe model: send tick gated by the phase, one cycle later
	always @(posedge i_clk) ps <= o_send_tick && i_sync_phase;
	always @(negedge i_clk) if (!i_rst) chk(o_send_strobe, ps);

	initial begin
		logic [31:0] q;
		logic [7:0] t, x, s;
		logic [2:0] cd [6];
		int i;
		cd = '{3'h1, 3'h3, 3'h5, 3'h0, 3'h2, 3'h7};
		void'($urandom(16190));
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		rd_chk(4'h0, 8'h00);
		rd_chk(4'h4, 8'h00);
		rd_chk(4'h8, 8'h21);
		rd_chk(4'hc, 8'h00);
		period(0, 2);
		period(3, 8);
		// the sweep drives six of the eight codes (1, 3, 5, 0, 2, 7), legal rates or not, to cover the decode
		for (i = 0; i < 12; i++) begin
			t = {i[0], cd[i % 6], 1'b0, cd[(i / 2) % 6]};
			x = 8'($urandom);
			s = {t[7], 3'(sdiv(t)), 1'b0, 3'(cdiv(t[2:0]))};
			bus(1'b1, 4'h0, t | 8'h08, q);
			bus(1'b1, 4'h4, x, q);
			rd_chk(4'h0, t);
			rd_chk(4'h4, x);
			rd_chk(4'h8, s);
			chk(o_sync_offset, x[4:0]);
			chk(o_ultra_en, t[7]);
			period(0, sdiv(t));
			period(1, cdiv(t[2:0]));
			period(2, 4 * sdiv(t));
			period(3, sdiv(t) * (4 + x[7:5]));
		end
		i_byteenable <= 4'he;
		bus(1'b1, 4'h4, 8'hff, q);
		i_byteenable <= 4'hf;
		rd_chk(4'h4, x);
		@(posedge i_clk);
		// sync /2 keeps the divided clock at 50 MHz, so no ultra rate is tried
		i_script_wr <= '{we: 1'b1, addr: 4'h0, data: 8'hb5};
		@(posedge i_clk);
		// smallest send divider, as software is told to prefer
		i_script_wr <= '{we: 1'b1, addr: 4'h4, data: 8'h07};
		@(posedge i_clk);
		i_script_wr <= '{we: 1'b1, addr: 4'h8, data: 8'h11};
		@(posedge i_clk);
		i_script_wr <= '0;
		rd_chk(4'h0, 8'hb5);
		rd_chk(4'h4, 8'h07);
		period(3, 2 * 4);
		period(1, 4);
		// a second reset in mid-run must bring back the reset rates
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		rd_chk(4'h0, 8'h00);
		rd_chk(4'h8, 8'h21);
		period(0, 2);
		report_and_stop();
	end
endmodule // tb_sync_scsi_rate_divider
`default_nettype wire
